// *** rtl/rcl_device.sv ***
// Purpose: Converter end: range register loaded over DDR serial input
// Assumes: Link clock is slow against clk, sampled and edge detected
// Notes: Conversion is a timed busy pulse whose length tracks enabled channels
`timescale 1ns/1ps
module rcl_device #(
    parameter int BOOT_CYCLES = rcl_pkg::BOOT_CYCLES
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    rcl_link_if.dev                    link,
    input  wire logic                  convert_start,
    output logic [rcl_pkg::WORD_W-1:0] range_cfg,
    output logic [rcl_pkg::NUM_CH-1:0] ch_enabled,
    output logic                       window_open,
    output logic                       word_loaded
);
    typedef enum logic [1:0]
    {
        RCL_BOOT = 2'b00,
        RCL_WIN  = 2'b01,
        RCL_CONV = 2'b11
    } rcl_dstate_t;

    // Channel n owns one 3-bit slice, code zero switches it off
    function automatic logic code_on(input logic [23:0] cfg, input int ch);
        return cfg[ch*rcl_pkg::CODE_W +: rcl_pkg::CODE_W] != rcl_pkg::CODE_OFF;
    endfunction

    // Six bits: all eight channels on gives more than a 5-bit count holds
    function automatic logic [5:0] conv_len(input logic [23:0] cfg);
        logic [5:0] n;
        n = 6'(rcl_pkg::CONV_BASE);
        for (int i = 0; i < rcl_pkg::NUM_CH; i++)
        begin
            if (code_on(cfg, i))
            begin
                n = n + 6'(rcl_pkg::CONV_PER_CH);
            end
        end
        return n;
    endfunction

    logic        sck_s;
    logic        sdi_s;
    logic        csn_s;
    logic        sck_d_r;
    rcl_dstate_t state_r;
    rcl_dstate_t state_nxt;
    logic [23:0] boot_cnt_r;
    logic        boot_done;
    logic [5:0]  conv_cnt_r;
    logic        conv_done;
    logic [4:0]  edge_cnt_r;
    logic [4:0]  edge_cnt_nxt;
    logic        word_end;
    logic [23:0] shift_r;
    logic [23:0] range_r;
    logic        loaded_r;
    logic        in_window;
    logic        sck_edge;
    logic        load_ok;
    logic [23:0] word_nxt;

    // Pins are asynchronous to clk, two flops before any logic
    rcl_sync u_sck
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (link.serial_clock_input),
        .q     (sck_s)
    );
    rcl_sync u_sdi
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (link.serial_config_input),
        .q     (sdi_s)
    );
    rcl_sync #(.RST_VAL(1'b1)) u_csn
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (link.cs_n),
        .q     (csn_s)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sck_d_r <= 1'b0;
        else
            sck_d_r <= sck_s;
    end

    assign in_window = (state_r == RCL_WIN);
    // Rising and falling edges both count, only with the bus enabled
    assign sck_edge  = (sck_s ^ sck_d_r) && !csn_s && in_window;
    assign word_nxt  = {shift_r[22:0], sdi_s};
    // Twenty-fourth edge is the twelfth falling edge in DDR use
    assign word_end  = sck_edge && (edge_cnt_r == rcl_pkg::LAST_EDGE);
    // All-zero word keeps the old ranges, so an idle low line is harmless
    assign load_ok   = word_end && (word_nxt != 24'h000000);
    assign boot_done = (boot_cnt_r >= 24'(BOOT_CYCLES - 1));
    assign conv_done = (conv_cnt_r == 6'h01);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            RCL_BOOT:
            begin
                if (boot_done)
                begin
                    state_nxt = RCL_WIN;
                end
            end
            RCL_WIN:
            begin
                if (convert_start)
                begin
                    state_nxt = RCL_CONV;
                end
            end
            RCL_CONV:
            begin
                if (conv_done)
                begin
                    state_nxt = RCL_WIN;
                end
            end
            default:
            begin
                state_nxt = RCL_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= RCL_BOOT;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Counter freezes once the first window opens
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_cnt_r <= 24'h000000;
        end
        else if (state_r == RCL_BOOT)
        begin
            boot_cnt_r <= boot_cnt_r + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_cnt_r <= 6'h00;
        end
        else if (in_window && convert_start)
        begin
            // Length read at start: a setting loaded before start applies now; a word ending in the start cycle applies next time
            conv_cnt_r <= conv_len(range_r);
        end
        else if (state_r == RCL_CONV)
        begin
            conv_cnt_r <= conv_cnt_r - 6'h01;
        end
    end

    always_comb
    begin
        edge_cnt_nxt = edge_cnt_r;
        if (word_end)
        begin
            edge_cnt_nxt = 5'h00;
        end
        else if (sck_edge)
        begin
            edge_cnt_nxt = edge_cnt_r + 5'h01;
        end
    end

    // Edge count restarts with each window, so partial words never carry into the next window
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_cnt_r <= 5'h00;
        end
        else if (!in_window)
        begin
            edge_cnt_r <= 5'h00;
        end
        else
        begin
            edge_cnt_r <= edge_cnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_r <= 24'h000000;
        end
        else if (sck_edge)
        begin
            shift_r <= word_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            range_r <= rcl_pkg::RANGE_RESET;
        end
        else if (load_ok)
        begin
            range_r <= word_nxt;
        end
    end

    // One-cycle pulse lets the user time the next conversion
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded_r <= 1'b0;
        end
        else
        begin
            loaded_r <= load_ok;
        end
    end

    always_comb
    begin
        for (int i = 0; i < rcl_pkg::NUM_CH; i++)
        begin
            ch_enabled[i] = code_on(range_r, i);
        end
    end

    assign range_cfg                     = range_r;
    assign word_loaded                   = loaded_r;
    assign window_open                   = (state_r == RCL_WIN);
    assign link.busy                     = (state_r != RCL_WIN);
    // Echo clock floats when deselected so the bus can be shared
    assign link.serial_clock_echo_output = sck_s;
    assign link.serial_clock_echo_oe     = !csn_s;
endmodule

// *** rtl/rcl_pkg.sv ***
// Purpose: Shared constants for the range configuration loader link
// Assumes: 10 MHz system clock on both ends
// Notes: Words are 24 bits, eight 3-bit channel codes, MSB first
package rcl_pkg;
    localparam int           WORD_W        = 24;
    localparam int           CODE_W        = 3;
    localparam int           NUM_CH        = 8;
    localparam int           CNT_W         = 5;
    localparam logic [4:0]   LAST_EDGE     = 5'h17;
    localparam logic [23:0]  RANGE_RESET   = 24'hffffff;
    localparam logic [2:0]   CODE_OFF      = 3'h0;
    localparam int           CLK_HZ        = 10_000_000;
    localparam int           BOOT_WAIT_MS  = 10;
    localparam int           BOOT_CYCLES   = BOOT_WAIT_MS * (CLK_HZ / 1000);
    localparam int           SCK_HALF      = 4;
    localparam int           CONV_BASE     = 8;
    localparam int           CONV_PER_CH   = 4;
endpackage

// *** rtl/rcl_link_if.sv ***
// Purpose: Pins between host and loader
// Assumes: Both ends on one 10 MHz clock domain family
// Notes: Differential pairs are carried as logical levels
`timescale 1ns/1ps
interface rcl_link_if;
    logic serial_clock_input;
    logic serial_config_input;
    logic cs_n;
    logic busy;
    logic serial_clock_echo_output;
    logic serial_clock_echo_oe;
    modport dev
    (
        input  serial_clock_input,
        input  serial_config_input,
        input  cs_n,
        output busy,
        output serial_clock_echo_output,
        output serial_clock_echo_oe
    );
    modport host
    (
        output serial_clock_input,
        output serial_config_input,
        output cs_n,
        input  busy,
        input  serial_clock_echo_output,
        input  serial_clock_echo_oe
    );
endinterface

// *** rtl/rcl_sync.sv ***
// Purpose: Two-flop synchroniser for one pin
// Assumes: Input is asynchronous to clk
// Notes: Reset value is a parameter constant
`timescale 1ns/1ps
module rcl_sync #(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// *** rtl/rcl_host.sv ***
// Purpose: Host end: sends one range word in DDR per request
// Assumes: Device busy low means the window is open
// Notes: Divider makes the link clock; data held low when idle
`timescale 1ns/1ps
module rcl_host
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    rcl_link_if.host                   link,
    input  wire logic                  send_req,
    input  wire logic [rcl_pkg::WORD_W-1:0] send_word,
    output logic                       send_ready,
    output logic                       send_done
);
    typedef enum logic [1:0] {RCH_IDLE = 2'b00, RCH_WAIT = 2'b01, RCH_SHIFT = 2'b11} rcl_hstate_t;

    logic        busy_s;
    rcl_hstate_t state_r;
    logic [23:0] word_r;
    logic [4:0]  edge_cnt_r;
    logic [2:0]  div_r;
    logic        sck_r;
    logic        sdi_r;
    logic        csn_r;
    logic        done_r;
    logic        tick;

    rcl_sync #(.RST_VAL(1'b1)) u_busy (.clk(clk), .rst_n(rst_n), .d(link.busy), .q(busy_s));

    assign tick = (div_r == 3'(rcl_pkg::SCK_HALF - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= RCH_IDLE;
            word_r     <= 24'h000000;
            edge_cnt_r <= 5'h00;
            div_r      <= 3'h0;
            sck_r      <= 1'b0;
            sdi_r      <= 1'b0;
            csn_r      <= 1'b1;
            done_r     <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                RCH_IDLE:
                begin
                    sdi_r <= 1'b0;
                    if (send_req)
                    begin
                        word_r  <= send_word;
                        state_r <= RCH_WAIT;
                    end
                end
                RCH_WAIT:
                begin
                    if (!busy_s)
                    begin
                        csn_r      <= 1'b0; // Clock still low here
                        sdi_r      <= word_r[23];
                        word_r     <= {word_r[22:0], 1'b0};
                        div_r      <= 3'h0;
                        edge_cnt_r <= 5'h00;
                        state_r    <= RCH_SHIFT;
                    end
                end
                RCH_SHIFT:
                begin
                    div_r <= tick ? 3'h0 : div_r + 3'h1;
                    // Data moves one clk after a link edge: held on that edge, set up for the next
                    if (div_r == 3'h0 && edge_cnt_r != 5'h00 && edge_cnt_r <= rcl_pkg::LAST_EDGE)
                    begin
                        sdi_r  <= word_r[23];
                        word_r <= {word_r[22:0], 1'b0};
                    end
                    if (tick)
                    begin
                        if (edge_cnt_r == rcl_pkg::LAST_EDGE + 5'h01)
                        begin
                            csn_r   <= 1'b1; // Clock idles low as select rises
                            sdi_r   <= 1'b0;
                            done_r  <= 1'b1;
                            state_r <= RCH_IDLE;
                        end
                        else
                        begin
                            sck_r      <= ~sck_r;
                            edge_cnt_r <= edge_cnt_r + 5'h01;
                        end
                    end
                end
                default:
                    state_r <= RCH_IDLE;
            endcase
        end
    end

    assign send_ready               = (state_r == RCH_IDLE);
    assign send_done                = done_r;
    assign link.serial_clock_input  = sck_r;
    assign link.serial_config_input = sdi_r;
    assign link.cs_n                = csn_r;
endmodule

// *** testbench/rcl_link_sva.sv ***
// Purpose: Checks on the host to loader link
// Assumes: Loader built with BOOT_CYCLES of 20
// Notes: Watches the first link only
`timescale 1ns/1ps
module rcl_link_sva
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        serial_clock_input,
    input wire logic        serial_config_input,
    input wire logic        cs_n,
    input wire logic        busy,
    input wire logic        serial_clock_echo_oe,
    input wire logic        serial_clock_echo_output,
    input wire logic [23:0] range_cfg,
    input wire logic [7:0]  ch_enabled,
    input wire logic        window_open,
    input wire logic        word_loaded
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] en_exp;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            en_exp[i] = range_cfg[3*i +: 3] != 3'h0;
        end
    end
    sequence s_boot;
        busy && !window_open;
    endsequence
    sequence s_pulse;
        range_cfg != 24'h000000 ##1 !word_loaded;
    endsequence
    AST_RESET_VAL: assert property ($rose(rst_n) |-> range_cfg == 24'hffffff)
        else $error("range not all ones after reset");
    AST_BOOT_WINDOW: assert property ($rose(rst_n) |-> s_boot ##[15:25] window_open)
        else $error("boot window late or early");
    AST_LOAD_CHANGES: assert property ($changed(range_cfg) |-> word_loaded)
        else $error("range changed without load");
    AST_NO_ZERO_LOAD: assert property (word_loaded |-> s_pulse)
        else $error("zero word loaded or long pulse");
    AST_LOAD_IN_WINDOW: assert property (word_loaded |-> $past(window_open))
        else $error("load outside window");
    AST_CH_ENABLE: assert property (ch_enabled == en_exp)
        else $error("channel enable mismatch");
    AST_BUSY_FALL: assert property ($fell(busy) |-> $past(busy, 8))
        else $error("window opened after too short a busy time");
    AST_ECHO_ON: assert property ($fell(cs_n) |-> ##[1:3] serial_clock_echo_oe)
        else $error("echo not enabled");
    AST_ECHO_OFF: assert property ($rose(cs_n) |-> ##[1:3] !serial_clock_echo_oe)
        else $error("echo not released");
    AST_ECHO_COPY: assert property (
        serial_clock_echo_output == $past(serial_clock_input, 2))
        else $error("echo clock does not follow link clock");
    AST_SCK_IDLE: assert property ($changed(cs_n) |-> !serial_clock_input)
        else $error("link clock high at select change");
    AST_SDI_IDLE: assert property (cs_n |-> !serial_config_input)
        else $error("data high while deselected");
endmodule

// *** testbench/lvds_range_config_loader_tb_top.sv ***
// Purpose: Bench for host and loader facing each other
// Assumes: Boot waits cut to 20 and 300 cycles
// Notes: Second loader driven raw to send short and long even edge counts
`timescale 1ns/1ps
module lvds_range_config_loader_tb_top;
    logic        clk;
    logic        rst_n;
    logic        send_req;
    logic [23:0] send_word;
    logic        send_ready;
    logic        send_done;
    logic        convert_start;
    logic        convert_start2;
    logic [23:0] range_cfg;
    logic [23:0] range_cfg2;
    logic [7:0]  ch_enabled;
    logic        window_open;
    logic        window_open2;
    logic        word_loaded;
    logic        word_loaded2;
    int          fail_count = 0;
    int          checked = 0;
    int          loads = 0;
    int          loads2 = 0;
    int          cycles = 0;
    rcl_link_if link();
    rcl_link_if link2();
    rcl_host rcl_host_i (.clk(clk), .rst_n(rst_n), .link(link.host), .send_req(send_req),
        .send_word(send_word), .send_ready(send_ready), .send_done(send_done));
    rcl_device #(.BOOT_CYCLES(20)) rcl_device_i (.clk(clk), .rst_n(rst_n), .link(link.dev),
        .convert_start(convert_start), .range_cfg(range_cfg), .ch_enabled(ch_enabled),
        .window_open(window_open), .word_loaded(word_loaded));
    rcl_device #(.BOOT_CYCLES(300)) rcl_device_b_i (.clk(clk), .rst_n(rst_n), .link(link2.dev),
        .convert_start(convert_start2), .range_cfg(range_cfg2), .ch_enabled(),
        .window_open(window_open2), .word_loaded(word_loaded2));
    rcl_link_sva rcl_link_sva_i (.clk(clk), .rst_n(rst_n),
        .serial_clock_input(link.serial_clock_input),
        .serial_config_input(link.serial_config_input), .cs_n(link.cs_n), .busy(link.busy),
        .serial_clock_echo_oe(link.serial_clock_echo_oe),
        .serial_clock_echo_output(link.serial_clock_echo_output), .range_cfg(range_cfg),
        .ch_enabled(ch_enabled), .window_open(window_open), .word_loaded(word_loaded));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        loads <= loads + int'(word_loaded === 1'b1);
        loads2 <= loads2 + int'(word_loaded2 === 1'b1);
        if (cycles == 5000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic ok, string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic host_send(logic [23:0] w, logic [23:0] exp, int nload);
        int n;
        n = loads;
        chk(send_ready === 1'b1, "host not ready");
        send_word = w;
        send_req = 1'b1;
        step(1);
        send_req = 1'b0;
        for (int i = 0; i < 400 && send_done !== 1'b1; i++) step(1);
        step(8);
        chk(range_cfg === exp, "range after send");
        chk(loads - n == nload, "load pulse count");
    endtask
    task automatic conv(int len);
        int n;
        n = 0;
        convert_start = 1'b1;
        step(1);
        convert_start = 1'b0;
        while (link.busy === 1'b1 && n < 200)
        begin
            n++;
            step(1);
        end
        chk(n == len, "conversion length");
        chk(window_open === 1'b1, "window after conversion");
    endtask
    // Even edge counts only, so the link clock always rests low
    task automatic raw(int n, logic [47:0] pat, logic sel_n, logic [23:0] exp, int nload);
        int c;
        c = loads2;
        link2.cs_n = sel_n;
        step(4);
        for (int i = 0; i < n; i++)
        begin
            link2.serial_config_input = (i < 48) ? pat[47-i] : 1'b0;
            step(3);
            link2.serial_clock_input = ~link2.serial_clock_input;
            step(1);
        end
        step(4);
        link2.cs_n = 1'b1;
        // Released line shows the inverse, not a stale value
        link2.serial_config_input = ~link2.serial_config_input;
        step(4);
        chk(range_cfg2 === exp, "raw range");
        chk(loads2 - c == nload, "raw load count");
    endtask
    // Closing the window must drop a partial word left in the count
    task automatic conv2();
        convert_start2 = 1'b1;
        step(1);
        chk(window_open2 === 1'b0, "second window still open");
        convert_start2 = 1'b0;
        for (int i = 0; i < 100 && window_open2 !== 1'b1; i++) step(1);
        chk(window_open2 === 1'b1, "second window not reopened");
    endtask
    initial
    begin
        rst_n = 1'b0;
        send_req = 1'b0;
        send_word = 24'h000000;
        convert_start = 1'b0;
        convert_start2 = 1'b0;
        link2.cs_n = 1'b1;
        link2.serial_clock_input = 1'b0;
        link2.serial_config_input = 1'b0;
        step(5);
        rst_n = 1'b1;
        chk(range_cfg === rcl_pkg::RANGE_RESET && link.busy === 1'b1, "reset state");
        step(25);
        chk(window_open === 1'b1 && window_open2 === 1'b0, "boot windows");
        raw(24, {24'h333333, 24'h000000}, 1'b0, 24'hffffff, 0);
        for (int i = 0; i < 400 && window_open2 !== 1'b1; i++) step(1);
        raw(22, {24'h5a5a5a, 24'h000000}, 1'b0, 24'hffffff, 0);
        conv2();
        raw(24, {24'h333333, 24'h000000}, 1'b1, 24'hffffff, 0);
        raw(52, {24'h111111, 24'h2a2a2a}, 1'b0, 24'h2a2a2a, 2);
        host_send(24'h123456, 24'h123456, 1);
        chk(ch_enabled === 8'h7f, "enables after word");
        host_send(24'h000000, 24'h123456, 0);
        conv(36);
        host_send(24'hffffff, 24'hffffff, 1);
        conv(40);
        host_send(24'hfff000, 24'hfff000, 1);
        conv(24);
        end_sim();
    end
endmodule
